// ==== core/svc_cache_arr.sv ====
// one two-way set-associative tag/data array with lru bits
// assumes the owner serialises writes; lookup is combinational
`timescale 1ns/1ns
module svc_cache_arr #(
  parameter int IDX_W = 8,
  parameter int TAG_W = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic flush,
  input wire logic [IDX_W-1:0] lk_idx,
  input wire logic [TAG_W-1:0] lk_tag,
  output logic hit,
  output logic hit_way,
  output logic [svc_pkg::LINE_W-1:0] hit_line,
  output logic vict_way,
  input wire logic wr_en,
  input wire logic lru_en,
  input wire logic [IDX_W-1:0] up_idx,
  input wire logic up_way,
  input wire logic [TAG_W-1:0] up_tag,
  input wire logic [svc_pkg::LINE_W-1:0] up_line
);
  localparam int SETS = 1 << IDX_W;
  typedef struct packed {
    logic [1:0][SETS-1:0] vld;
    logic [SETS-1:0] lru; // way to replace next
  } svc_arr_type;
  svc_arr_type s_q, s_d;
  logic [TAG_W-1:0] tag_m [2][SETS];
  logic [svc_pkg::LINE_W-1:0] dat_m [2][SETS];
  logic h0, h1;

  // ==========================================================
  // lookup
  assign h0 = s_q.vld[0][lk_idx] && tag_m[0][lk_idx] == lk_tag;
  assign h1 = s_q.vld[1][lk_idx] && tag_m[1][lk_idx] == lk_tag;
  assign hit = h0 | h1;
  assign hit_way = h1;
  assign hit_line = h1 ? dat_m[1][lk_idx] : dat_m[0][lk_idx];
  assign vict_way = s_q.lru[lk_idx];

  // ==========================================================
  // valid and lru update; flush wins over a same-cycle fill
  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.vld[up_way][up_idx] = 1'b1;
    end
    if (wr_en || lru_en) begin
      s_d.lru[up_idx] = ~up_way;
    end
    if (flush) begin
      s_d.vld = '0;
    end
  end

  // reset invalidates every line
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // tag and data storage needs no reset, valid bits guard it
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      tag_m[up_way][up_idx] <= up_tag;
      dat_m[up_way][up_idx] <= up_line;
    end
  end
endmodule : svc_cache_arr

// ==== core/svc_cache_pair.sv ====
// split instruction and data cache pair with one memory sequencer
// assumes core holds a request until its ack; memory acks each word
//
// Contract
// - icache: 16K bytes, 1024 lines of 16 bytes, 2-way, virtual tags
// - icache uses core virtual addresses, refills one whole line per miss
// - icache enable bit, reset clears it and invalidates all lines
// - clearing icache enable keeps valid bits, old lines hit again
// - enabled icache looked up on every fetch, hits regardless of mmu
// - icache miss fetches full line into lru-chosen way
// - icache off: no lookup, each fetch one 16 or 32 bit access
// - block register load never issues a burst read
// - icache flush invalidates whole cache before next opcode executes
// - dcache: 8K bytes, 512 lines of 16 bytes, 2-way, virtual tags
// - dcache inactive whenever mmu disabled, whatever its enable bit
// - page attributes select write-through or copy-back per access
// - dcache enable bit, reset clears it and invalidates all lines
// - dcache serves byte, halfword and word loads and stores
// - dcache on: every access looks up, load hits ignore cacheable
// - load miss: line fill if cacheable, else single access, no update
// - store hits always update line, store misses never allocate
// - little-endian byte order only
// - write-through: hit writes cache and memory, write miss memory only
// - copy-back: hits stay local, write miss one external access
// - dcache enable 0: no search, contents kept for re-enable
`timescale 1ns/1ns
module svc_cache_pair (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  input wire logic if_half,
  output logic if_ack,
  output logic [31:0] if_data,
  input wire logic d_req,
  input wire logic d_we,
  input wire logic [31:0] d_addr,
  input wire logic [1:0] d_size,
  input wire logic [31:0] d_wdata,
  input wire logic d_block,
  input wire logic page_cacheable_attr,
  input wire logic page_bufferable_attr,
  output logic d_ack,
  output logic [31:0] d_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic mem_burst,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  localparam int LW = svc_pkg::LINE_W;
  localparam int ICI = svc_pkg::IC_IDX_W;
  localparam int ICT = svc_pkg::IC_TAG_W;
  localparam int DCI = svc_pkg::DC_IDX_W;
  localparam int DCT = svc_pkg::DC_TAG_W;
  localparam int LO = svc_pkg::LINE_LO;

  typedef struct packed {
    svc_pkg::svc_st_type st;
    logic ic_en;
    logic dc_en;
    logic mmu_en;
    logic if_ack;
    logic [31:0] if_data;
    logic d_ack;
    logic [31:0] d_rdata;
    logic [31:0] reg_rdata;
    logic mem_req;
    logic mem_we;
    logic mem_burst;
    logic [31:0] mem_addr;
    logic [1:0] mem_size;
    logic [31:0] mem_wdata;
    logic [31:0] p_addr;
    logic [1:0] p_size;
    logic vict;
    logic [1:0] cnt;
    logic [LW-1:0] lbuf;
  } svc_top_type;
  svc_top_type s_q, s_d;

  logic ic_hit, ic_hway, ic_vict, ic_wr, ic_lru, ic_fl, ic_way;
  logic dc_hit, dc_hway, dc_vict, dc_wr, dc_lru, dc_fl, dc_way;
  logic [LW-1:0] ic_line, dc_line, up_line;
  logic dc_on, take_d, take_i, cb;

  // ==========================================================
  // little-endian lane helpers
  function automatic logic [31:0] wsel(input logic [LW-1:0] l,
                                       input logic [1:0] w);
    wsel = l[w*32 +: 32];
  endfunction : wsel

  function automatic logic [3:0] lanes(input logic [1:0] a,
                                       input logic [1:0] sz);
    logic [3:0] m;
    m = (sz == svc_pkg::SZ_BYTE) ? 4'h1 :
        (sz == svc_pkg::SZ_HALF) ? 4'h3 : 4'hf;
    lanes = m << a;
  endfunction : lanes

  // loads come back right aligned and zero extended
  function automatic logic [31:0] ld_fmt(input logic [31:0] w,
                                         input logic [1:0] a,
                                         input logic [1:0] sz);
    logic [31:0] v;
    v = w >> {a, 3'b000};
    ld_fmt = (sz == svc_pkg::SZ_BYTE) ? {24'h00_0000, v[7:0]} :
             (sz == svc_pkg::SZ_HALF) ? {16'h0000, v[15:0]} : v;
  endfunction : ld_fmt

  function automatic logic [31:0] st_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [1:0] a,
                                           input logic [1:0] sz);
    logic [3:0] be;
    logic [31:0] sh;
    be = lanes(a, sz);
    sh = wd << {a, 3'b000};
    for (int i = 0; i < 4; i++) begin
      st_merge[i*8 +: 8] = be[i] ? sh[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : st_merge

  // ==========================================================
  // tag/data arrays, indexed and tagged by virtual address
  svc_cache_arr #(.IDX_W(ICI), .TAG_W(ICT)) u_icache (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(ic_fl),
    .lk_idx(if_addr[LO +: ICI]),
    .lk_tag(if_addr[31 -: ICT]),
    .hit(ic_hit),
    .hit_way(ic_hway),
    .hit_line(ic_line),
    .vict_way(ic_vict),
    .wr_en(ic_wr),
    .lru_en(ic_lru),
    .up_idx(ic_wr ? s_q.p_addr[LO +: ICI] : if_addr[LO +: ICI]),
    .up_way(ic_way),
    .up_tag(s_q.p_addr[31 -: ICT]),
    .up_line(up_line)
  );

  svc_cache_arr #(.IDX_W(DCI), .TAG_W(DCT)) u_dcache (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(dc_fl),
    .lk_idx(d_addr[LO +: DCI]),
    .lk_tag(d_addr[31 -: DCT]),
    .hit(dc_hit),
    .hit_way(dc_hway),
    .hit_line(dc_line),
    .vict_way(dc_vict),
    .wr_en(dc_wr),
    .lru_en(dc_lru),
    .up_idx(s_q.st == svc_pkg::ST_IDLE ? d_addr[LO +: DCI]
                                       : s_q.p_addr[LO +: DCI]),
    .up_way(dc_way),
    .up_tag(s_q.st == svc_pkg::ST_IDLE ? d_addr[31 -: DCT]
                                       : s_q.p_addr[31 -: DCT]),
    .up_line(up_line)
  );

  // ==========================================================
  // request qualification; an acked request is not taken twice
  assign dc_on = s_q.dc_en & s_q.mmu_en;
  assign cb = page_cacheable_attr & page_bufferable_attr;
  assign take_d = s_q.st == svc_pkg::ST_IDLE && d_req && !s_q.d_ack;
  assign take_i = s_q.st == svc_pkg::ST_IDLE && !take_d && if_req &&
                  !s_q.if_ack;

  // sequencer, register port and array write control
  always_comb begin
    logic [LW-1:0] nl;
    nl = s_q.lbuf;
    nl[s_q.cnt*32 +: 32] = mem_rdata;
    s_d = s_q;
    s_d.if_ack = 1'b0;
    s_d.d_ack = 1'b0;
    s_d.reg_rdata = '0;
    ic_wr = 1'b0;
    ic_lru = 1'b0;
    ic_way = s_q.vict;
    dc_wr = 1'b0;
    dc_lru = 1'b0;
    dc_way = s_q.vict;
    up_line = nl;
    ic_fl = reg_wr && reg_addr == svc_pkg::REG_FLUSH &&
            reg_wdata[svc_pkg::FLUSH_IC];
    dc_fl = reg_wr && reg_addr == svc_pkg::REG_FLUSH &&
            reg_wdata[svc_pkg::FLUSH_DC];
    // enables only steer lookup, valid bits stay
    if (reg_wr && reg_addr == svc_pkg::REG_CTRL) begin
      s_d.ic_en = reg_wdata[svc_pkg::CTRL_IC_EN];
      s_d.dc_en = reg_wdata[svc_pkg::CTRL_DC_EN];
      s_d.mmu_en = reg_wdata[svc_pkg::CTRL_MMU_EN];
    end
    if (reg_rd) begin
      case (reg_addr)
        svc_pkg::REG_CTRL: s_d.reg_rdata = {29'h0000_0000, s_q.mmu_en,
                                            s_q.dc_en, s_q.ic_en};
        svc_pkg::REG_STAT: s_d.reg_rdata = {29'h0000_0000, s_q.st};
        default: s_d.reg_rdata = '0;
      endcase
    end
    case (s_q.st)
      svc_pkg::ST_IDLE: begin
        s_d.cnt = '0;
        s_d.p_addr = take_d ? d_addr : if_addr;
        s_d.p_size = d_size;
        s_d.mem_addr = take_d ? d_addr : if_addr;
        s_d.mem_size = d_size;
        s_d.mem_wdata = d_wdata << {d_addr[1:0], 3'b000};
        if (take_d && d_we) begin
          // store: hit updates line, miss never allocates
          if (dc_on && dc_hit) begin
            dc_wr = 1'b1;
            dc_way = dc_hway;
            up_line = dc_line;
            up_line[d_addr[3:2]*32 +: 32] =
              st_merge(wsel(dc_line, d_addr[3:2]), d_wdata,
                       d_addr[1:0], d_size);
          end
          if (dc_on && dc_hit && cb) begin
            s_d.d_ack = 1'b1; // copy-back hit stays local
            s_d.d_rdata = '0; // store acks carry no data
          end else begin
            s_d.mem_req = 1'b1; // write-through or miss
            s_d.mem_we = 1'b1;
            s_d.st = svc_pkg::ST_D_WRITE;
          end
        end else if (take_d) begin
          if (dc_on && dc_hit) begin
            dc_lru = 1'b1;
            dc_way = dc_hway;
            s_d.d_ack = 1'b1;
            s_d.d_rdata = ld_fmt(wsel(dc_line, d_addr[3:2]),
                                 d_addr[1:0], d_size);
          end else if (dc_on && page_cacheable_attr && !d_block) begin
            s_d.vict = dc_vict;
            s_d.mem_req = 1'b1;
            s_d.mem_burst = 1'b1;
            s_d.mem_addr = {d_addr[31:LO], 4'h0};
            s_d.mem_size = svc_pkg::SZ_WORD;
            s_d.st = svc_pkg::ST_D_FILL;
          end else begin
            s_d.mem_req = 1'b1; // no burst for block loads
            s_d.st = svc_pkg::ST_D_SINGLE;
          end
        end else if (take_i) begin
          s_d.mem_size = if_half ? svc_pkg::SZ_HALF : svc_pkg::SZ_WORD;
          if (s_q.ic_en && ic_hit) begin
            ic_lru = 1'b1; // hit with mmu on or off
            ic_way = ic_hway;
            s_d.if_ack = 1'b1;
            s_d.if_data = wsel(ic_line, if_addr[3:2]);
          end else if (s_q.ic_en) begin
            s_d.vict = ic_vict;
            s_d.mem_req = 1'b1;
            s_d.mem_burst = 1'b1;
            s_d.mem_addr = {if_addr[31:LO], 4'h0};
            s_d.mem_size = svc_pkg::SZ_WORD;
            s_d.st = svc_pkg::ST_I_FILL;
          end else begin
            s_d.mem_req = 1'b1; // disabled: one plain fetch
            s_d.st = svc_pkg::ST_I_SINGLE;
          end
        end
      end
      svc_pkg::ST_I_FILL, svc_pkg::ST_D_FILL: begin
        // whole line, words in ascending order
        if (mem_ack) begin
          s_d.lbuf = nl;
          s_d.cnt = s_q.cnt + 2'h1;
          if (s_q.cnt == svc_pkg::LAST_WORD) begin
            s_d.mem_req = 1'b0;
            s_d.mem_burst = 1'b0;
            s_d.st = svc_pkg::ST_IDLE;
            if (s_q.st == svc_pkg::ST_I_FILL) begin
              ic_wr = 1'b1;
              s_d.if_ack = 1'b1;
              s_d.if_data = wsel(nl, s_q.p_addr[3:2]);
            end else begin
              dc_wr = 1'b1;
              s_d.d_ack = 1'b1;
              s_d.d_rdata = ld_fmt(wsel(nl, s_q.p_addr[3:2]),
                                   s_q.p_addr[1:0], s_q.p_size);
            end
          end
        end
      end
      svc_pkg::ST_I_SINGLE, svc_pkg::ST_D_SINGLE,
      svc_pkg::ST_D_WRITE: begin
        if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          s_d.st = svc_pkg::ST_IDLE;
          if (s_q.st == svc_pkg::ST_I_SINGLE) begin
            s_d.if_ack = 1'b1;
            s_d.if_data = mem_rdata;
          end else begin
            s_d.d_ack = 1'b1;
            s_d.d_rdata = s_q.st == svc_pkg::ST_D_WRITE ? '0 :
              ld_fmt(mem_rdata, s_q.p_addr[1:0], s_q.p_size);
          end
        end
      end
      default: s_d.st = svc_pkg::ST_IDLE;
    endcase
  end

  // state register; reset clears all three enables
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all registered
  assign reg_rdata = s_q.reg_rdata;
  assign if_ack = s_q.if_ack;
  assign if_data = s_q.if_data;
  assign d_ack = s_q.d_ack;
  assign d_rdata = s_q.d_rdata;
  assign mem_req = s_q.mem_req;
  assign mem_we = s_q.mem_we;
  assign mem_burst = s_q.mem_burst;
  assign mem_addr = s_q.mem_addr;
  assign mem_size = s_q.mem_size;
  assign mem_wdata = s_q.mem_wdata;

  // ==========================================================
  // checks
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_ic_off_single: assert property (
    take_i && !s_q.ic_en |=> s_q.st == svc_pkg::ST_I_SINGLE &&
      mem_req && !mem_burst)
    else $error("disabled icache fetch not single");
  chk_ic_miss_fill: assert property (
    take_i && s_q.ic_en && !ic_hit |=>
      s_q.st == svc_pkg::ST_I_FILL && mem_burst && mem_addr[3:0] == 4'h0)
    else $error("icache miss without line fill");
  chk_dc_mmu_off: assert property (
    take_d && !d_we && !s_q.mmu_en |=> s_q.st == svc_pkg::ST_D_SINGLE)
    else $error("dcache used with mmu off");
  chk_nc_load_miss: assert property (
    take_d && !d_we && dc_on && !dc_hit && !page_cacheable_attr |->
      !dc_wr ##1 !mem_burst)
    else $error("noncacheable miss filled a line");
  chk_block_noburst: assert property (
    take_d && d_block |=> !mem_burst)
    else $error("block load issued burst");
  chk_cb_hit_local: assert property (
    take_d && d_we && dc_on && dc_hit && cb |-> dc_wr ##1
      (d_ack && !mem_req))
    else $error("copy-back hit went external");
  chk_wt_hit_ext: assert property (
    take_d && d_we && dc_on && dc_hit && !cb |-> dc_wr ##1
      (mem_req && mem_we) [*1] ##0 s_q.st == svc_pkg::ST_D_WRITE)
    else $error("write-through hit not written out");
  chk_store_miss: assert property (
    s_q.st == svc_pkg::ST_D_WRITE || (take_d && d_we && !dc_hit)
      |-> !dc_wr)
    else $error("store miss touched dcache");
  chk_ic_flush: assert property (
    ic_fl |=> !ic_hit)
    else $error("icache hit after flush");
  chk_fill_len: assert property (
    $fell(mem_burst) |-> $past(mem_ack) &&
      $past(s_q.cnt) == svc_pkg::LAST_WORD)
    else $error("line fill not four words");

  cov_ic_hit: cover property (take_i && s_q.ic_en && ic_hit);
  cov_dc_fill: cover property (s_q.st == svc_pkg::ST_D_FILL && mem_ack &&
    s_q.cnt == svc_pkg::LAST_WORD);
  cov_cb_store: cover property (take_d && d_we && dc_on && dc_hit && cb);
endmodule : svc_cache_pair

// ==== core/svc_pkg.sv ====
// package for the split instruction/data cache pair
// assumes one core clock and a 32-bit external memory bus
package svc_pkg;
  // ==========================================================
  // line geometry
  localparam int LINE_LO = 4;
  localparam int LINE_W = 128;
  localparam logic [1:0] LAST_WORD = 2'h3;
  localparam int IC_IDX_W = 9; // 512 sets x 2 ways = 1024 lines
  localparam int IC_TAG_W = 19;
  localparam int DC_IDX_W = 8; // 256 sets x 2 ways = 512 lines
  localparam int DC_TAG_W = 20;
  // ==========================================================
  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLUSH = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTRL_IC_EN = 0;
  localparam int CTRL_DC_EN = 1;
  localparam int CTRL_MMU_EN = 2;
  localparam int FLUSH_IC = 0;
  localparam int FLUSH_DC = 1;
  // ==========================================================
  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_I_FILL = 3'b001,
    ST_I_SINGLE = 3'b010,
    ST_D_FILL = 3'b011,
    ST_D_SINGLE = 3'b100,
    ST_D_WRITE = 3'b101
  } svc_st_type;
endpackage : svc_pkg

// ==== testbench/svc_mem_model.sv ====
// far-side memory model: one word per ack, optional wait states
// assumes the block holds mem_* steady until after its last ack
`timescale 1ns/1ns
module svc_mem_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_burst,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output int n_burst,
  output int n_single,
  output int n_write
);
  logic [7:0] mem [int];
  logic [1:0] beat_q;
  logic last_q, sel;
  logic [31:0] a_w;
  int wait_q;

  // ==========================================================
  // contents never written read back as a pattern of the address
  function automatic logic [7:0] rd_b(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'(a ^ (a >> 10));
  endfunction : rd_b

  // ==========================================================
  // the edge that sees the last ack is not taken as a new request
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      beat_q <= 2'h0;
      last_q <= 1'b0;
      wait_q <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // released bus never holds a stale word
      if (mem_req && !(mem_ack && last_q)) begin
        if (wait_q != 0) begin
          wait_q <= wait_q - 1;
        end else begin
          a_w = mem_burst ? {mem_addr[31:4], beat_q, 2'b00}
                          : {mem_addr[31:2], 2'b00};
          mem_ack <= 1'b1;
          wait_q <= slow ? 3 : 0;
          last_q <= !mem_burst || beat_q == 2'h3;
          beat_q <= mem_burst ? beat_q + 2'h1 : 2'h0;
          for (int i = 0; i < 4; i++) begin
            sel = mem_size == 2'h2 || i[1:0] == mem_addr[1:0]
                || (mem_size == 2'h1 && i[1] == mem_addr[1]);
            mem_rdata[8*i +: 8] <= rd_b(a_w + i); // lane i, byte i
            if (mem_we && sel) mem[a_w + i] = mem_wdata[8*i +: 8];
          end
          if (beat_q == 2'h0) begin
            if (mem_burst) n_burst <= n_burst + 1;
            else if (mem_we) n_write <= n_write + 1;
            else n_single <= n_single + 1;
          end
        end
      end
    end
  end
endmodule : svc_mem_model

// ==== testbench/tb_svc_cache_pair.sv ====
// bench for the split cache pair: drives core and register ports,
// keeps a byte view of memory and checks every result, and every bus count outside the random loop
// assumes svc_mem_model answers the external bus
`timescale 1ns/1ns
module tb_svc_cache_pair;
  logic clk_sys, resetn, reg_wr, reg_rd, if_req, if_half, if_ack, slow;
  logic d_req, d_we, d_block, d_ack, mem_req, mem_we, mem_burst, mem_ack;
  logic page_cacheable_attr, page_bufferable_attr;
  logic [3:0] reg_addr;
  logic [1:0] d_size, mem_size, sz;
  logic [31:0] reg_wdata, reg_rdata, if_addr, if_data, d_addr, d_wdata;
  logic [31:0] d_rdata, mem_addr, mem_wdata, mem_rdata, rv, a;
  int n_burst, n_single, n_write, b0, s0, w0, n_errors, compares, seed;
  logic [7:0] cv [int];

  svc_cache_pair u_dut (.*);
  svc_mem_model u_mem (.*);

  // ==========================================================
  // 250 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reference view of memory as the core should see it
  function automatic logic [7:0] cvb(input logic [31:0] x);
    return cv.exists(x) ? cv[x] : 8'(x ^ (x >> 10));
  endfunction : cvb

  task automatic chk(input bit ok, input string what);
    compares++;
    if (!ok) begin
      n_errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk

  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // external traffic since last call; a negative burst count skips the check
  task automatic mcnt(input int eb, es, ew);
    if (eb >= 0) chk(n_burst - b0 == eb && n_single - s0 == es
        && n_write - w0 == ew, "memory traffic");
    b0 = n_burst;
    s0 = n_single;
    w0 = n_write;
  endtask : mcnt

  task automatic reg_w(input logic [3:0] ra, input logic [31:0] d);
    reg_addr <= ra;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_w

  // read data stand only in the cycle after the strobe
  task automatic reg_r(input logic [3:0] ra, input logic [31:0] e);
    reg_addr <= ra;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata === e, "register read");
  endtask : reg_r

  task automatic ctl(input logic [2:0] v);
    reg_w(svc_pkg::REG_CTRL, {29'h0000_0000, v});
  endtask : ctl

  // bounded wait for the ack; a spare edge keeps strobes apart
  task automatic await(input bit ins, output logic [31:0] r);
    int k;
    for (k = 0; k < 80; k++) begin
      @(posedge clk_sys);
      if ((ins ? if_ack : d_ack) === 1'b1) break;
    end
    if (k == 80) begin
      n_errors++;
      $display("FAIL %0t no ack", $time);
      give_verdict;
    end
    r = ins ? if_data : d_rdata;
    if_req <= 1'b0;
    d_req <= 1'b0;
    @(posedge clk_sys);
  endtask : await

  task automatic fop(input logic [31:0] fa, input logic h, input int eb,
      es);
    logic [31:0] e, r;
    for (int k = 0; k < 4; k++) e[8*k +: 8] = cvb({fa[31:2], 2'b00} + k);
    if_addr <= fa;
    if_half <= h;
    if_req <= 1'b1;
    await(1'b1, r);
    chk(r === e, "fetch data");
    mcnt(eb, es, 0);
  endtask : fop

  task automatic dop(input logic we, input logic [31:0] da,
      input logic [1:0] s, input logic [31:0] wd, input logic c, b, blk,
      input int eb, es, ew);
    logic [31:0] e, r;
    e = 32'h0000_0000;
    for (int k = 0; k < (1 << s); k++) begin
      if (we) cv[da + k] = wd[8*k +: 8];
      else e[8*k +: 8] = cvb(da + k);
    end
    d_we <= we;
    d_addr <= da;
    d_size <= s;
    d_wdata <= wd;
    page_cacheable_attr <= c;
    page_bufferable_attr <= b;
    d_block <= blk;
    d_req <= 1'b1;
    await(1'b0, r);
    chk(r === e, "load data");
    mcnt(eb, es, ew);
  endtask : dop

  // ==========================================================
  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, if_req, if_half, slow, d_req, d_we} = 8'h00;
    {d_block, page_cacheable_attr, page_bufferable_attr} = 3'h0;
    {reg_addr, d_size, reg_wdata, if_addr, d_addr, d_wdata} = '0;
    seed = 67;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    reg_r(svc_pkg::REG_CTRL, 32'h0000_0000);
    reg_w(4'hc, 32'hffff_ffff);
    reg_r(4'hc, 32'h0000_0000);
    reg_r(svc_pkg::REG_STAT, 32'h0000_0000);
    fop(32'h0000_8000, 1'b0, 0, 1);
    fop(32'h0000_8006, 1'b1, 0, 1);
    dop(0, 32'h0000_5000, 2'h2, 0, 1, 0, 0, 0, 1, 0);
    ctl(3'h7);
    reg_r(svc_pkg::REG_CTRL, 32'h0000_0007);
    fop(32'h0000_8004, 1'b0, 1, 0);
    fop(32'h0000_8008, 1'b0, 0, 0);
    ctl(3'h3);
    fop(32'h0000_800c, 1'b0, 0, 0);
    ctl(3'h6);
    fop(32'h0000_8000, 1'b0, 0, 1);
    ctl(3'h7);
    fop(32'h0000_8000, 1'b0, 0, 0);
    reg_w(svc_pkg::REG_FLUSH, 32'h0000_0001);
    repeat (4) @(posedge clk_sys); // four no-op slots after flush
    fop(32'h0000_8000, 1'b0, 1, 0);
    fop(32'h0000_a000, 1'b0, 1, 0);
    fop(32'h0000_8000, 1'b0, 0, 0);
    fop(32'h0000_c000, 1'b0, 1, 0);
    fop(32'h0000_8000, 1'b0, 0, 0);
    fop(32'h0000_a000, 1'b0, 1, 0);
    dop(0, 32'h0000_1000, 2'h2, 0, 1, 1, 0, 1, 0, 0);
    dop(0, 32'h0000_1003, 2'h0, 0, 1, 1, 0, 0, 0, 0);
    dop(1, 32'h0000_1002, 2'h1, 32'h0000_beef, 1, 1, 0, 0, 0, 0);
    dop(0, 32'h0000_1000, 2'h2, 0, 1, 1, 0, 0, 0, 0);
    dop(1, 32'h0000_1001, 2'h0, 32'h0000_005a, 1, 0, 0, 0, 0, 1);
    dop(1, 32'h0000_1004, 2'h2, 32'hc0de_0001, 0, 0, 0, 0, 0, 1);
    dop(0, 32'h0000_1004, 2'h2, 0, 0, 0, 0, 0, 0, 0);
    dop(1, 32'h0000_5000, 2'h2, 32'h1234_5678, 1, 0, 0, 0, 0, 1);
    dop(0, 32'h0000_5000, 2'h2, 0, 1, 0, 0, 1, 0, 0);
    dop(1, 32'h0000_6000, 2'h1, 32'h0000_a5a5, 1, 1, 0, 0, 0, 1);
    dop(0, 32'h0000_6000, 2'h2, 0, 1, 1, 0, 1, 0, 0);
    dop(0, 32'h0000_7000, 2'h2, 0, 0, 0, 0, 0, 1, 0);
    dop(0, 32'h0000_7000, 2'h2, 0, 0, 0, 0, 0, 1, 0);
    dop(0, 32'h0000_7100, 2'h2, 0, 1, 0, 1, 0, 1, 0);
    ctl(3'h3);
    dop(0, 32'h0000_5004, 2'h2, 0, 1, 0, 0, 0, 1, 0);
    ctl(3'h5);
    dop(0, 32'h0000_5004, 2'h2, 0, 1, 0, 0, 0, 1, 0);
    ctl(3'h7);
    dop(0, 32'h0000_5004, 2'h2, 0, 1, 0, 0, 0, 0, 0);
    reg_w(svc_pkg::REG_FLUSH, 32'h0000_0002);
    dop(0, 32'h0000_5004, 2'h2, 0, 1, 0, 0, 1, 0, 0);
    // random write-through traffic over three tags of a few sets
    for (int i = 0; i < 80; i++) begin
      rv = $random(seed);
      sz = 2'(rv[1:0] % 3);
      a = 32'h0000_2100 + (rv[3:2] % 3) * 32'h0000_1000 + rv[9:4];
      a = (a >> sz) << sz;
      slow <= rv[12];
      dop(rv[10], a, sz, $random(seed), 1, 0, 0, -1, 0, 0);
    end
    give_verdict;
  end
endmodule : tb_svc_cache_pair
